// [core/servo_cmd_regs.vh]
/*
 * Register offsets, field positions, reset values and timing counts for
 * the servo command input decoder. Included by bare name; assumes the
 * includer uses a 25 MHz pclk.
 */
// Behaviour
// - Decode step/direction, up/down or quadrature pulses; format from setup two bits 3-5.
// - Command pulses up to 200 kpps are accepted; controller must stay below.
// - Asserting the deviation counter clear input zeroes the position error counter.
// - Setup two bit 10 picks level-held or rising-edge clearing.
// - Setup one bit 0 clear: servo enabled only while run input asserted.
// - Setup one bit 0 set: run input ignored, servo always enabled.
// - Select 0/1, or 3-5 with both speed selects off: input reduces gain.
// - Select 7, 8 or 9: input switches to alternate control mode.
// - Select 10: input locks position while speed at or below threshold.
// - Select 11: input ignores all command pulses; they no longer reach the error counter.
// - Select 3 to 6: current-limit inputs become preset speed selects.
`ifndef SERVO_CMD_REGS_VH
`define SERVO_CMD_REGS_VH

// register byte offsets
`define REG_SETUP_ONE     8'h00
`define REG_SETUP_TWO     8'h04
`define REG_FUNC_SELECT   8'h08
`define REG_HOLD_SPEED    8'h0c
`define REG_STATUS        8'h10
`define REG_ERROR_COUNT   8'h14

// field positions
`define SETUP_ONE_FORCE_ON  0
`define SETUP_TWO_FMT_LSB   3
`define SETUP_TWO_FMT_MSB   5
`define SETUP_TWO_CLR_EDGE  10
`define STAT_SERVO_ON       0
`define STAT_GAIN_REDUCE    1
`define STAT_MODE_SWITCH    2
`define STAT_POS_HOLD       3
`define STAT_INHIBIT        4
`define STAT_OVERRATE       5

// reset values
`define SETUP_ONE_RESET   32'h0000_0000
`define SETUP_TWO_RESET   32'h0000_0000
`define FUNC_SELECT_RESET 4'h0
`define HOLD_SPEED_RESET  16'h0000

// pulse format codes
`define FMT_STEP_DIR  3'h0
`define FMT_CW_CCW    3'h1
`define FMT_QUAD_X1   3'h2
`define FMT_QUAD_X2   3'h3
`define FMT_QUAD_X4   3'h4

// timing
`define CLK_KHZ            25000
`define MAX_PULSE_KPPS     200
`define MIN_PULSE_CYCLES   (`CLK_KHZ / `MAX_PULSE_KPPS)

`endif

// [core/pin_sync.v]
/*
 * Two-flop synchroniser for a bundle of asynchronous pins.
 * Assumes every bit is independent; no bus coherence across bits.
 */
`timescale 1ns/100ps
module pin_sync #(
    parameter WIDTH = 1
) (
    // clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // pins
    input  wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] pin_out
);
    reg [WIDTH-1:0] stage_one;
    reg [WIDTH-1:0] stage_two;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage_one[i] <= 1'b0;
                    stage_two[i] <= 1'b0;
                end else begin
                    stage_one[i] <= pin_in[i];
                    stage_two[i] <= stage_one[i];
                end
            end
        end
    endgenerate

    assign pin_out = stage_two;
endmodule // pin_sync

// [core/servo_command_input_decoder.v]
/*
 * Servo command input decoder: pulse train decoding into a position
 * error counter, counter clearing, servo enable gating and the
 * multi-function input router, with an APB register slave.
 * Assumes all control pins are asynchronous to pclk and that
 * motor_speed comes from logic on pclk.
 */
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "servo_cmd_regs.vh"
module servo_command_input_decoder #(
    parameter COUNT_WIDTH = 32,
    parameter SPEED_WIDTH = 16
) (
    // clock and reset
    input  wire                   pclk,
    input  wire                   presetn,
    // apb slave
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [7:0]             paddr,
    input  wire [31:0]            pwdata,
    output reg  [31:0]            prdata,
    output reg                    pready,
    output reg                    pslverr,
    // command pins: a = step/down/phase a, b = direction/up/phase b
    input  wire                   cmd_pulse_a,
    input  wire                   cmd_pulse_b,
    input  wire                   deviation_counter_clear,
    input  wire                   run_input,
    input  wire                   multi_function_input,
    input  wire                   fwd_limit_input,
    input  wire                   rev_limit_input,
    // drive feedback, same clock
    input  wire signed [SPEED_WIDTH-1:0] motor_speed,
    // drive controls
    output reg                    servo_on,
    output reg                    gain_reduce_input,
    output reg                    control_mode_switch_input,
    output reg                    position_hold_input,
    output reg                    step_inhibit_input,
    output reg                    fwd_current_limit,
    output reg                    rev_current_limit,
    output reg  [1:0]             preset_speed_sel,
    output reg  [COUNT_WIDTH-1:0] error_count
);
    localparam GAP_WIDTH = 8;
    localparam integer MIN_GAP_CYCLES = `MIN_PULSE_CYCLES;
    localparam [GAP_WIDTH-1:0] MIN_GAP = MIN_GAP_CYCLES[GAP_WIDTH-1:0];

    // synchronised pins
    wire [6:0] pins_s;

    pin_sync #(
        .WIDTH (7)
    ) u_pin_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin_in  ({rev_limit_input, fwd_limit_input,
                   multi_function_input, run_input,
                   deviation_counter_clear, cmd_pulse_b, cmd_pulse_a}),
        .pin_out (pins_s)
    );

    wire       a_s            = pins_s[0];
    wire       b_s            = pins_s[1];
    wire       clr_s          = pins_s[2];
    wire       run_s          = pins_s[3];
    wire       mf_s           = pins_s[4];
    wire       speed_select_0 = pins_s[5];
    wire       speed_select_1 = pins_s[6];

    // software registers
    reg [31:0]            setup_param_one;
    reg [31:0]            setup_param_two;
    reg [3:0]             multi_function_select;
    reg [SPEED_WIDTH-1:0] hold_speed_threshold;
    reg                   pulse_overrate;

    // edge history
    reg a_q;
    reg b_q;
    reg clr_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_q   <= 1'b0;
            b_q   <= 1'b0;
            clr_q <= 1'b0;
        end else begin
            a_q   <= a_s;
            b_q   <= b_s;
            clr_q <= clr_s;
        end
    end

    // pulse decode
    reg        step_up;
    reg        step_down;
    wire [2:0] fmt = setup_param_two[`SETUP_TWO_FMT_MSB:`SETUP_TWO_FMT_LSB];
    wire       feed_step_input             = a_s & ~a_q;
    wire       clockwise_step_input        = a_s & ~a_q;
    wire       counterclockwise_step_input = b_s & ~b_q;
    wire       a_edge  = a_s ^ a_q;
    wire       b_edge  = b_s ^ b_q;
    wire       ab_diff = a_s ^ b_s;

    // phase a leading phase b counts forward
    always @* begin
        step_up   = 1'b0;
        step_down = 1'b0;
        case (fmt)
            `FMT_STEP_DIR: begin
                step_up   = feed_step_input & ~b_s;
                step_down = feed_step_input & b_s;
            end
            `FMT_CW_CCW: begin
                // coincident pulses cancel
                step_up   = counterclockwise_step_input
                          & ~clockwise_step_input;
                step_down = clockwise_step_input
                          & ~counterclockwise_step_input;
            end
            `FMT_QUAD_X1: begin
                step_up   = a_s & ~a_q & ~b_s;
                step_down = a_s & ~a_q & b_s;
            end
            `FMT_QUAD_X2: begin
                step_up   = a_edge & ab_diff;
                step_down = a_edge & ~ab_diff;
            end
            `FMT_QUAD_X4: begin
                step_up   = (a_edge & ab_diff) | (b_edge & ~ab_diff);
                step_down = (a_edge & ~ab_diff) | (b_edge & ab_diff);
            end
            default: begin
                // reserved codes count nothing rather than guess
            end
        endcase
    end

    // multi-function routing
    wire [SPEED_WIDTH-1:0] speed_mag;

    wire   sel_gain_a  = (multi_function_select == 4'h0)
                       | (multi_function_select == 4'h1);
    wire   sel_gain_b  = (multi_function_select >= 4'h3)
                       & (multi_function_select <= 4'h5);
    wire   sel_speed   = (multi_function_select >= 4'h3)
                       & (multi_function_select <= 4'h6);
    wire   sel_mode    = (multi_function_select >= 4'h7)
                       & (multi_function_select <= 4'h9);
    wire   sel_hold    = (multi_function_select == 4'ha);
    wire   sel_inhibit = (multi_function_select == 4'hb);

    assign speed_mag = motor_speed[SPEED_WIDTH-1] ?
                       (~motor_speed + 1'b1) : motor_speed;

    wire   next_gain = mf_s & (sel_gain_a
                     | (sel_gain_b & ~speed_select_0 & ~speed_select_1));
    wire   next_mode = mf_s & sel_mode;
    wire   next_hold = mf_s & sel_hold
                     & (speed_mag <= hold_speed_threshold);
    wire   next_inhibit = mf_s & sel_inhibit;
    wire   next_servo_on = setup_param_one[`SETUP_ONE_FORCE_ON]
                         | run_s;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            servo_on                  <= 1'b0;
            gain_reduce_input         <= 1'b0;
            control_mode_switch_input <= 1'b0;
            position_hold_input       <= 1'b0;
            step_inhibit_input        <= 1'b0;
            fwd_current_limit         <= 1'b0;
            rev_current_limit         <= 1'b0;
            preset_speed_sel          <= 2'h0;
        end else begin
            servo_on                  <= next_servo_on;
            gain_reduce_input         <= next_gain;
            control_mode_switch_input <= next_mode;
            position_hold_input       <= next_hold;
            step_inhibit_input        <= next_inhibit;
            if (sel_speed) begin
                fwd_current_limit <= 1'b0;
                rev_current_limit <= 1'b0;
                preset_speed_sel  <= {speed_select_1, speed_select_0};
            end else begin
                fwd_current_limit <= speed_select_0;
                rev_current_limit <= speed_select_1;
                preset_speed_sel  <= 2'h0;
            end
        end
    end

    // position error counter
    wire clear_now;
    wire count_up;
    wire count_down;

    assign clear_now = setup_param_two[`SETUP_TWO_CLR_EDGE] ?
                       (clr_s & ~clr_q) : clr_s;
    // inhibit is decided from the live input so no pulse slips through
    assign count_up   = step_up & ~next_inhibit;
    assign count_down = step_down & ~next_inhibit;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            error_count <= {COUNT_WIDTH{1'b0}};
        end else if (clear_now) begin
            error_count <= {COUNT_WIDTH{1'b0}};
        end else if (count_up) begin
            error_count <= error_count + 1'b1;
        end else if (count_down) begin
            error_count <= error_count - 1'b1;
        end
    end

    // pulse rate watch: edges closer than the rated period flag overrate
    reg  [GAP_WIDTH-1:0] pulse_gap;
    wire                 any_step;
    wire                 rate_fault;

    assign any_step   = step_up | step_down;
    assign rate_fault = any_step & (pulse_gap < MIN_GAP);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_gap <= MIN_GAP;
        end else if (any_step) begin
            pulse_gap <= {{(GAP_WIDTH-1){1'b0}}, 1'b1};
        end else if (pulse_gap < MIN_GAP) begin
            pulse_gap <= pulse_gap + 1'b1;
        end
    end

    // apb slave, one wait state so read data leaves a flip-flop
    wire apb_access;
    wire apb_write;
    wire addr_ok;
    reg  [31:0] next_prdata;

    assign apb_access = psel & penable & ~pready;
    assign apb_write  = psel & penable & pready & pwrite;
    assign addr_ok    = (paddr == `REG_SETUP_ONE)
                      | (paddr == `REG_SETUP_TWO)
                      | (paddr == `REG_FUNC_SELECT)
                      | (paddr == `REG_HOLD_SPEED)
                      | (paddr == `REG_STATUS)
                      | (paddr == `REG_ERROR_COUNT);

    always @* begin
        next_prdata = 32'h0000_0000;
        if (paddr == `REG_SETUP_ONE) begin
            next_prdata = setup_param_one;
        end else if (paddr == `REG_SETUP_TWO) begin
            next_prdata = setup_param_two;
        end else if (paddr == `REG_FUNC_SELECT) begin
            next_prdata[3:0] = multi_function_select;
        end else if (paddr == `REG_HOLD_SPEED) begin
            next_prdata[SPEED_WIDTH-1:0] = hold_speed_threshold;
        end else if (paddr == `REG_STATUS) begin
            next_prdata[`STAT_SERVO_ON]    = servo_on;
            next_prdata[`STAT_GAIN_REDUCE] = gain_reduce_input;
            next_prdata[`STAT_MODE_SWITCH] = control_mode_switch_input;
            next_prdata[`STAT_POS_HOLD]    = position_hold_input;
            next_prdata[`STAT_INHIBIT]     = step_inhibit_input;
            next_prdata[`STAT_OVERRATE]    = pulse_overrate;
        end else if (paddr == `REG_ERROR_COUNT) begin
            next_prdata = error_count;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (apb_access) begin
            pready  <= 1'b1;
            pslverr <= ~addr_ok;
            prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_param_one       <= `SETUP_ONE_RESET;
            setup_param_two       <= `SETUP_TWO_RESET;
            multi_function_select <= `FUNC_SELECT_RESET;
            hold_speed_threshold  <= `HOLD_SPEED_RESET;
        end else if (apb_write) begin
            if (paddr == `REG_SETUP_ONE) begin
                setup_param_one <= pwdata;
            end else if (paddr == `REG_SETUP_TWO) begin
                setup_param_two <= pwdata;
            end else if (paddr == `REG_FUNC_SELECT) begin
                multi_function_select <= pwdata[3:0];
            end else if (paddr == `REG_HOLD_SPEED) begin
                hold_speed_threshold <= pwdata[SPEED_WIDTH-1:0];
            end
        end
    end

    // sticky overrate, write one to clear; a new fault wins the clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_overrate <= 1'b0;
        end else if (rate_fault) begin
            pulse_overrate <= 1'b1;
        end else if (apb_write && (paddr == `REG_STATUS)
                     && pwdata[`STAT_OVERRATE]) begin
            pulse_overrate <= 1'b0;
        end
    end
endmodule // servo_command_input_decoder

// [sim/cmd_pulse_source.sv]
/* behavioural motion controller: one command step per go request,
   in the pulse format on fmt. assumes the decoder samples on pclk. */
`timescale 1ns/100ps
module cmd_pulse_source #(
    parameter GAP = 130
) (
    // clock
    input wire       pclk,
    // request
    input wire       go,
    input wire       rev,
    input wire [2:0] fmt,
    output reg       busy,
    // command pins
    output reg       cmd_pulse_a,
    output reg       cmd_pulse_b
);
    // every pin edge waits GAP cycles, just inside the top pulse rate
    task move(input logic na, input logic nb);
        begin
            repeat (GAP) @(posedge pclk);
            cmd_pulse_a <= na;
            cmd_pulse_b <= nb;
        end
    endtask

    initial begin
        busy = 1'b0;
        cmd_pulse_a = 1'b0;
        cmd_pulse_b = 1'b0;
    end

    // codes above up/down all get one full quadrature cycle
    always @(posedge pclk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            if (fmt == 3'h0) begin
                move(1'b0, rev);
                move(1'b1, rev);
            end else if (fmt == 3'h1) begin
                move(rev, !rev);
            end else begin
                move(!rev, rev);
                move(1'b1, 1'b1);
                move(rev, !rev);
            end
            move(1'b0, 1'b0);
            move(1'b0, 1'b0);
            busy <= 1'b0;
        end
    end
endmodule // cmd_pulse_source

// [sim/servo_decoder_props.sv]
/* port checks for the servo command input decoder. config is shadowed
   from apb writes; pin checks wait until a write has settled. */
`timescale 1ns/100ps
module servo_decoder_props #(
    parameter COUNT_WIDTH = 32
) (
    // clock and reset
    input wire                   pclk,
    input wire                   presetn,
    // apb
    input wire                   psel,
    input wire                   penable,
    input wire                   pwrite,
    input wire [7:0]             paddr,
    input wire [31:0]            pwdata,
    input wire                   pready,
    // pins
    input wire                   deviation_counter_clear,
    input wire                   run_input,
    input wire                   multi_function_input,
    input wire                   fwd_limit_input,
    input wire                   rev_limit_input,
    // drive controls
    input wire                   servo_on,
    input wire                   gain_reduce_input,
    input wire                   control_mode_switch_input,
    input wire                   step_inhibit_input,
    input wire [1:0]             preset_speed_sel,
    input wire [COUNT_WIDTH-1:0] error_count
);
    reg       force_on;
    reg       edge_clr;
    reg [3:0] sel;
    reg [2:0] age;
    wire      quiet = (age == 3'h7);
    wire      clr = deviation_counter_clear;
    wire      mf = multi_function_input;
    wire      spd = (sel > 4'h2) && (sel < 4'h7);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_on <= 1'b0;
            edge_clr <= 1'b0;
            sel <= 4'h0;
            age <= 3'h0;
        end else if (psel && penable && pready && pwrite) begin
            age <= 3'h0;
            if (paddr == 8'h00) force_on <= pwdata[0];
            if (paddr == 8'h04) edge_clr <= pwdata[10];
            if (paddr == 8'h08) sel <= pwdata[3:0];
        end else if (!quiet) begin
            age <= age + 3'h1;
        end
    end

    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    property p_answer;
        s_setup ##1 s_access |-> !pready ##1 pready;
    endproperty
    a_answer: assert property (p_answer) else $error("wait state");
    property p_servo_force;
        quiet && force_on |-> servo_on;
    endproperty
    a_servo_force: assert property (p_servo_force)
        else $error("servo not forced");
    property p_servo_run;
        quiet && !force_on |-> servo_on == $past(run_input, 3);
    endproperty
    a_servo_run: assert property (p_servo_run)
        else $error("servo vs run");
    property p_clear_level;
        quiet && !edge_clr && $past(clr, 3) |-> error_count == '0;
    endproperty
    a_clear_level: assert property (p_clear_level)
        else $error("level clear");
    property p_clear_edge;
        quiet && edge_clr && $past(clr, 3) && !$past(clr, 4)
            |-> error_count == '0;
    endproperty
    a_clear_edge: assert property (p_clear_edge)
        else $error("edge clear");
    property p_gain;
        quiet |-> gain_reduce_input == ($past(mf, 3) && (sel < 4'h2 ||
            (spd && sel != 4'h6 && !$past(fwd_limit_input, 3) &&
            !$past(rev_limit_input, 3))));
    endproperty
    a_gain: assert property (p_gain) else $error("gain");
    property p_mode;
        quiet |-> control_mode_switch_input ==
            ($past(mf, 3) && sel > 4'h6 && sel < 4'ha);
    endproperty
    a_mode: assert property (p_mode) else $error("mode");
    property p_inhibit;
        quiet && sel == 4'hb |-> step_inhibit_input == $past(mf, 3);
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("inhibit");
    property p_speed_sel;
        quiet && spd |-> preset_speed_sel ==
            {$past(rev_limit_input, 3), $past(fwd_limit_input, 3)};
    endproperty
    a_speed_sel: assert property (p_speed_sel)
        else $error("speed select");
endmodule // servo_decoder_props

bind servo_command_input_decoder servo_decoder_props #(
    .COUNT_WIDTH(COUNT_WIDTH)
) servo_decoder_props_inst (.*);

// [sim/servo_command_input_decoder_test.sv]
/* self-checking bench for the servo command input decoder, with a
   behavioural controller on the pulse pins. assumes 25 MHz pclk. */
`timescale 1ns/100ps
module servo_command_input_decoder_test;
    reg               pclk = 1'b0, presetn = 1'b0, rd_e;
    reg               psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg        [7:0]  paddr = 8'h00;
    reg        [31:0] pwdata = 32'h0, rd_q;
    reg               deviation_counter_clear = 1'b0, run_input = 1'b0;
    reg               multi_function_input = 1'b0, go = 1'b0, rev = 1'b0;
    reg               fwd_limit_input = 1'b0, rev_limit_input = 1'b0;
    reg        [2:0]  fmt = 3'h0;
    reg signed [15:0] motor_speed = 16'sh0000;
    wire       [31:0] prdata, error_count;
    wire       [1:0]  preset_speed_sel;
    wire              pready, pslverr, cmd_pulse_a, cmd_pulse_b, busy;
    wire              servo_on, gain_reduce_input, step_inhibit_input;
    wire              control_mode_switch_input, position_hold_input;
    wire              fwd_current_limit, rev_current_limit;
    integer           fail_count = 0, n_checks = 0;

    always #20 pclk = ~pclk;

    servo_command_input_decoder servo_command_input_decoder_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cmd_pulse_a, .cmd_pulse_b, .run_input,
        .deviation_counter_clear, .multi_function_input, .fwd_limit_input,
        .rev_limit_input, .motor_speed, .servo_on, .gain_reduce_input,
        .control_mode_switch_input, .position_hold_input, .error_count,
        .step_inhibit_input, .fwd_current_limit, .rev_current_limit,
        .preset_speed_sel
    );
    cmd_pulse_source cmd_pulse_source_inst (
        .pclk, .go, .rev, .fmt, .busy, .cmd_pulse_a, .cmd_pulse_b
    );

    task check(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("[ERR] %0t got %h want %h", $time, got, exp);
            end
        end
    endtask

    task give_verdict;
        begin
            $display("checks %0d errors %0d", n_checks, fail_count);
            if (fail_count == 0 && n_checks > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask

    // idle cycle after each transfer so psel never changes twice at once
    task apb(input wr, input [7:0] a, input [31:0] d);
        integer n;
        begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge pclk);
                n = n + 1;
            end while (pready !== 1'b1 && n < 20);
            rd_q = prdata;
            rd_e = pslverr;
            check(n, 2);
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    task rd(input [7:0] a, input [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            check(rd_q, exp);
            check(rd_e, 1'b0);
        end
    endtask

    task settle;
        repeat (5) @(posedge pclk);
    endtask

    task step(input r);
        integer n;
        begin
            rev <= r;
            go <= 1'b1;
            @(posedge pclk);
            go <= 1'b0;
            n = 0;
            do begin
                @(posedge pclk);
                n = n + 1;
            end while (busy !== 1'b0 && n < 2000);
            settle;
        end
    endtask

    task t_regs;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) rd({i[5:0], 2'b00}, 32'h0);
            apb(1'b1, 8'h0c, 32'h0000_0064);
            rd(8'h0c, 32'h0000_0064);
            apb(1'b1, 8'h14, 32'h0000_0055);
            rd(8'h14, 32'h0);
            apb(1'b0, 8'h40, 32'h0);
            check(rd_e, 1'b1);
            check(rd_q, 32'h0);
        end
    endtask

    task t_formats;
        integer f, u;
        begin
            for (f = 0; f < 8; f = f + 1) begin
                apb(1'b1, 8'h04, f << 3);
                fmt <= f[2:0];
                deviation_counter_clear <= 1'b1;
                settle;
                deviation_counter_clear <= 1'b0;
                u = (f == 3) ? 2 : (f == 4) ? 4 : (f < 3) ? 1 : 0;
                step(1'b0);
                step(1'b0);
                check(error_count, 2 * u);
                step(1'b1);
                check(error_count, u);
            end
        end
    endtask

    task t_clear;
        begin
            apb(1'b1, 8'h04, 32'h0);
            fmt <= 3'h0;
            step(1'b0);
            deviation_counter_clear <= 1'b1;
            step(1'b0);
            check(error_count, 32'h0);
            deviation_counter_clear <= 1'b0;
            apb(1'b1, 8'h04, 32'h0000_0400);
            step(1'b0);
            deviation_counter_clear <= 1'b1;
            step(1'b0);
            check(error_count, 32'h1);
            deviation_counter_clear <= 1'b0;
        end
    endtask

    task t_servo;
        begin
            settle;
            check(servo_on, 1'b0);
            run_input <= 1'b1;
            settle;
            check(servo_on, 1'b1);
            run_input <= 1'b0;
            apb(1'b1, 8'h00, 32'h1);
            settle;
            check(servo_on, 1'b1);
            rd(8'h10, 32'h1);
            apb(1'b1, 8'h00, 32'h0);
            settle;
            check(servo_on, 1'b0);
        end
    endtask

    task t_route;
        integer s, l;
        reg sp;
        begin
            motor_speed <= 16'sd50;
            multi_function_input <= 1'b1;
            for (s = 0; s < 12; s = s + 1) begin
                apb(1'b1, 8'h08, s);
                sp = s > 2 && s < 7;
                for (l = 0; l < 4; l = l + 1) begin
                    {rev_limit_input, fwd_limit_input} <= l[1:0];
                    settle;
                    check(gain_reduce_input,
                        s < 2 || (sp && s < 6 && l == 0));
                    check(control_mode_switch_input,
                        s > 6 && s < 10);
                    check(position_hold_input, s == 10);
                    check(step_inhibit_input, s == 11);
                    check(preset_speed_sel, sp ? l : 0);
                    check({rev_current_limit, fwd_current_limit},
                        sp ? 0 : l);
                end
            end
            apb(1'b1, 8'h08, 32'd10);
            motor_speed <= 16'sd101;
            settle;
            check(position_hold_input, 1'b0);
            motor_speed <= -16'sd100;
            settle;
            check(position_hold_input, 1'b1);
            apb(1'b1, 8'h08, 32'd11);
            step(1'b0);
            check(error_count, 32'h1);
            multi_function_input <= 1'b0;
            step(1'b1);
            check(error_count, 32'h0);
        end
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs;
        t_formats;
        t_clear;
        t_servo;
        t_route;
        give_verdict;
    end

    // about twice the expected run length
    initial begin
        repeat (40000) @(posedge pclk);
        fail_count = fail_count + 1;
        give_verdict;
    end
endmodule // servo_command_input_decoder_test
